// ---- host_transport_idle_pkg.sv ----
package host_transport_idle_pkg;

	// Register byte offsets
	localparam logic [7:0] CMD_SHADOW_OFS = 8'h00;
	localparam logic [7:0] DEV_CTRL_OFS = 8'h04;
	localparam logic [7:0] DATA_SHADOW_OFS = 8'h08;
	localparam logic [7:0] APP_REQ_OFS = 8'h0c;
	localparam logic [7:0] STATUS_OFS = 8'h10;
	localparam int ADDR_LSB = 2;
	localparam int ADDR_MSB = 7;

	// Field positions
	localparam int SOFT_RESET_BIT = 2;
	localparam int REQ_DMA_SETUP_BIT = 0;
	localparam int REQ_SELF_TEST_BIT = 1;
	localparam int REQ_H2D_DIR_BIT = 2;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_CMD_PEND_BIT = 8;
	localparam int STAT_CTRL_PEND_BIT = 9;
	localparam int STAT_PIO_SEEN_BIT = 10;
	localparam int STAT_DATA_PEND_BIT = 11;
	localparam int STAT_DMA_PEND_BIT = 12;
	localparam int STAT_BIST_PEND_BIT = 13;
	localparam int STAT_H2D_BIT = 14;

	// Reset values
	localparam logic [7:0] CMD_SHADOW_RST = 8'h00;
	localparam logic [7:0] DEV_CTRL_RST = 8'h00;
	localparam logic [31:0] DATA_SHADOW_RST = 32'h0000_0000;

	// AHB encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [6:0] {
		TRANSPORT_IDLE_STATE = 7'h01,
		COMMAND_FRAME_BUILD_STATE = 7'h02,
		CONTROL_FRAME_BUILD_STATE = 7'h04,
		FRAME_TYPE_CHECK_STATE = 7'h08,
		DMA_SETUP_TRANSMIT_STATE = 7'h10,
		SELF_TEST_TRANSMIT_STATE = 7'h20,
		PIO_OUTBOUND_TRANSFER_STATE = 7'h40
	} idle_state_t;

endpackage : host_transport_idle_pkg

// ---- host_transport_idle_dispatch.sv ----
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps

module host_transport_idle_dispatch (
	// Clock and reset
	input wire logic MCLK_IN,
	input wire logic RST_N_IN,
	// AHB-Lite slave
	input wire logic HSEL_IN,
	input wire logic [31:0] HADDR_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic [2:0] HSIZE_IN,
	input wire logic [31:0] HWDATA_IN,
	input wire logic HREADY_IN,
	output logic HREADYOUT_OUT,
	output logic HRESP_OUT,
	output logic [31:0] HRDATA_OUT,
	// Link layer
	input wire logic LINK_RX_FRAME_IN,
	input wire logic LINK_TX_OK_IN,
	// Received type decode
	input wire logic RX_TYPE_VALID_IN,
	input wire logic RX_IS_PIO_SETUP_IN,
	// Sub-machine completion
	input wire logic SUB_DONE_IN,
	// Status
	output host_transport_idle_pkg::idle_state_t STATE_OUT,
	output logic CMD_PENDING_OUT,
	output logic CTRL_PENDING_OUT,
	output logic PIO_SETUP_SEEN_OUT,
	output logic SOFT_RESET_OUT
);
	import host_transport_idle_pkg::*;

	idle_state_t state_r;
	idle_state_t state_nxt;

	logic wr_pend_r;
	logic [ADDR_MSB:ADDR_LSB] wr_idx_r;
	logic [7:0] cmd_shadow_r;
	logic [7:0] dev_ctrl_r;
	logic [31:0] data_shadow_r;
	logic cmd_pend_r;
	logic ctrl_pend_r;
	logic data_pend_r;
	logic dma_req_r;
	logic bist_req_r;
	logic h2d_dir_r;
	logic pio_seen_r;

	logic addr_phase;
	logic wr_cmd;
	logic wr_ctrl;
	logic wr_data;
	logic wr_req;
	logic soft_reset_bit_change;
	logic [31:0] rd_word;
	logic tx_done;

	// Address phase accepted on any NONSEQ or SEQ transfer, whatever its size
	assign addr_phase = HSEL_IN && HREADY_IN && HTRANS_IN[1];

	always_ff @(posedge MCLK_IN) begin
		if (!RST_N_IN) begin
			wr_pend_r <= 1'b0;
			wr_idx_r <= '0;
		end else if (HREADY_IN) begin
			wr_pend_r <= addr_phase && HWRITE_IN;
			wr_idx_r <= HADDR_IN[ADDR_MSB:ADDR_LSB];
		end
	end

	assign wr_cmd = wr_pend_r && (wr_idx_r == CMD_SHADOW_OFS[ADDR_MSB:ADDR_LSB]);
	assign wr_ctrl = wr_pend_r && (wr_idx_r == DEV_CTRL_OFS[ADDR_MSB:ADDR_LSB]);
	assign wr_data = wr_pend_r && (wr_idx_r == DATA_SHADOW_OFS[ADDR_MSB:ADDR_LSB]);
	assign wr_req = wr_pend_r && (wr_idx_r == APP_REQ_OFS[ADDR_MSB:ADDR_LSB]);

	// Only a change of the soft-reset bit sends a control frame
	assign soft_reset_bit_change = wr_ctrl && (HWDATA_IN[SOFT_RESET_BIT] != dev_ctrl_r[SOFT_RESET_BIT]);

	always_ff @(posedge MCLK_IN) begin
		if (!RST_N_IN) begin
			cmd_shadow_r <= CMD_SHADOW_RST;
			dev_ctrl_r <= DEV_CTRL_RST;
			data_shadow_r <= DATA_SHADOW_RST;
		end else begin
			if (wr_cmd) begin
				cmd_shadow_r <= HWDATA_IN[7:0];
			end
			if (wr_ctrl) begin
				dev_ctrl_r <= HWDATA_IN[7:0];
			end
			if (wr_data) begin
				data_shadow_r <= HWDATA_IN;
			end
		end
	end

	assign tx_done = LINK_TX_OK_IN;

	// Command frame pending; a fresh write beats a same-cycle completion
	always_ff @(posedge MCLK_IN) begin
		if (!RST_N_IN) begin
			cmd_pend_r <= 1'b0;
		end else if (soft_reset_bit_change) begin
			cmd_pend_r <= 1'b0;
		end else if (wr_cmd) begin
			cmd_pend_r <= 1'b1;
		end else if (tx_done && state_r == COMMAND_FRAME_BUILD_STATE) begin
			cmd_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (!RST_N_IN) begin
			ctrl_pend_r <= 1'b0;
		end else if (soft_reset_bit_change) begin
			ctrl_pend_r <= 1'b1;
		end else if (tx_done && state_r == CONTROL_FRAME_BUILD_STATE) begin
			ctrl_pend_r <= 1'b0;
		end
	end

	// Outbound PIO data is signalled by data register writes
	always_ff @(posedge MCLK_IN) begin
		if (!RST_N_IN) begin
			data_pend_r <= 1'b0;
		end else if (wr_data) begin
			data_pend_r <= 1'b1;
		end else if (SUB_DONE_IN && state_r == PIO_OUTBOUND_TRANSFER_STATE) begin
			data_pend_r <= 1'b0;
		end
	end

	// Application requests; DMA and self-test: write of one sets, dispatch clears, set wins; direction bit loads on every write
	always_ff @(posedge MCLK_IN) begin
		if (!RST_N_IN) begin
			dma_req_r <= 1'b0;
			bist_req_r <= 1'b0;
			h2d_dir_r <= 1'b0;
		end else begin
			if (wr_req && HWDATA_IN[REQ_DMA_SETUP_BIT]) begin
				dma_req_r <= 1'b1;
			end else if (state_nxt == DMA_SETUP_TRANSMIT_STATE && state_r == TRANSPORT_IDLE_STATE) begin
				dma_req_r <= 1'b0;
			end
			if (wr_req && HWDATA_IN[REQ_SELF_TEST_BIT]) begin
				bist_req_r <= 1'b1;
			end else if (state_nxt == SELF_TEST_TRANSMIT_STATE && state_r == TRANSPORT_IDLE_STATE) begin
				bist_req_r <= 1'b0;
			end
			if (wr_req) begin
				h2d_dir_r <= HWDATA_IN[REQ_H2D_DIR_BIT];
			end
		end
	end

	// Last received frame type, kept for later dispatch
	always_ff @(posedge MCLK_IN) begin
		if (!RST_N_IN) begin
			pio_seen_r <= 1'b0;
		end else if (RX_TYPE_VALID_IN) begin
			pio_seen_r <= RX_IS_PIO_SETUP_IN;
		end
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			TRANSPORT_IDLE_STATE: begin
				if (LINK_RX_FRAME_IN) begin
					state_nxt = FRAME_TYPE_CHECK_STATE;
				end else if (cmd_pend_r) begin
					state_nxt = COMMAND_FRAME_BUILD_STATE;
				end else if (ctrl_pend_r) begin
					state_nxt = CONTROL_FRAME_BUILD_STATE;
				end else if (dma_req_r) begin
					state_nxt = DMA_SETUP_TRANSMIT_STATE;
				end else if (bist_req_r) begin
					state_nxt = SELF_TEST_TRANSMIT_STATE;
				end else if (pio_seen_r && h2d_dir_r && data_pend_r) begin
					state_nxt = PIO_OUTBOUND_TRANSFER_STATE;
				end else begin
					state_nxt = TRANSPORT_IDLE_STATE;
				end
			end
			COMMAND_FRAME_BUILD_STATE: begin
				if (soft_reset_bit_change) begin
					state_nxt = TRANSPORT_IDLE_STATE;
				end else if (LINK_RX_FRAME_IN) begin
					state_nxt = FRAME_TYPE_CHECK_STATE;
				end else if (tx_done) begin
					state_nxt = TRANSPORT_IDLE_STATE;
				end
			end
			CONTROL_FRAME_BUILD_STATE: begin
				if (LINK_RX_FRAME_IN) begin
					state_nxt = FRAME_TYPE_CHECK_STATE;
				end else if (tx_done) begin
					state_nxt = TRANSPORT_IDLE_STATE;
				end
			end
			FRAME_TYPE_CHECK_STATE,
			DMA_SETUP_TRANSMIT_STATE,
			SELF_TEST_TRANSMIT_STATE,
			PIO_OUTBOUND_TRANSFER_STATE: begin
				if (SUB_DONE_IN) begin
					state_nxt = TRANSPORT_IDLE_STATE;
				end
			end
			default: begin
				state_nxt = TRANSPORT_IDLE_STATE;
			end
		endcase
	end

	// Pending flags survive a preemption, so idle retries the frame
	always_ff @(posedge MCLK_IN) begin
		if (!RST_N_IN) begin
			state_r <= TRANSPORT_IDLE_STATE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_comb begin
		rd_word = '0;
		case (HADDR_IN[ADDR_MSB:ADDR_LSB])
			CMD_SHADOW_OFS[ADDR_MSB:ADDR_LSB]: begin
				rd_word[7:0] = cmd_shadow_r;
			end
			DEV_CTRL_OFS[ADDR_MSB:ADDR_LSB]: begin
				rd_word[7:0] = dev_ctrl_r;
			end
			DATA_SHADOW_OFS[ADDR_MSB:ADDR_LSB]: begin
				rd_word = data_shadow_r;
			end
			APP_REQ_OFS[ADDR_MSB:ADDR_LSB]: begin
				rd_word[REQ_DMA_SETUP_BIT] = dma_req_r;
				rd_word[REQ_SELF_TEST_BIT] = bist_req_r;
				rd_word[REQ_H2D_DIR_BIT] = h2d_dir_r;
			end
			STATUS_OFS[ADDR_MSB:ADDR_LSB]: begin
				rd_word[STAT_STATE_LSB +: 7] = state_r;
				rd_word[STAT_CMD_PEND_BIT] = cmd_pend_r;
				rd_word[STAT_CTRL_PEND_BIT] = ctrl_pend_r;
				rd_word[STAT_PIO_SEEN_BIT] = pio_seen_r;
				rd_word[STAT_DATA_PEND_BIT] = data_pend_r;
				rd_word[STAT_DMA_PEND_BIT] = dma_req_r;
				rd_word[STAT_BIST_PEND_BIT] = bist_req_r;
				rd_word[STAT_H2D_BIT] = h2d_dir_r;
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	// Read data captured at the address phase: zero wait states
	always_ff @(posedge MCLK_IN) begin
		if (!RST_N_IN) begin
			HRDATA_OUT <= '0;
			HREADYOUT_OUT <= 1'b1;
			HRESP_OUT <= HRESP_OKAY;
		end else begin
			HREADYOUT_OUT <= 1'b1;
			HRESP_OUT <= HRESP_OKAY;
			if (addr_phase && !HWRITE_IN) begin
				HRDATA_OUT <= rd_word;
			end
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (!RST_N_IN) begin
			STATE_OUT <= TRANSPORT_IDLE_STATE;
			CMD_PENDING_OUT <= 1'b0;
			CTRL_PENDING_OUT <= 1'b0;
			PIO_SETUP_SEEN_OUT <= 1'b0;
			SOFT_RESET_OUT <= 1'b0;
		end else begin
			STATE_OUT <= state_nxt;
			CMD_PENDING_OUT <= cmd_pend_r;
			CTRL_PENDING_OUT <= ctrl_pend_r;
			PIO_SETUP_SEEN_OUT <= pio_seen_r;
			SOFT_RESET_OUT <= dev_ctrl_r[SOFT_RESET_BIT];
		end
	end

endmodule : host_transport_idle_dispatch

// ---- host_transport_idle_checker.sv ----
`timescale 1ns/1ps
module host_transport_idle_checker (
	// Watched ports
	input wire logic MCLK_IN,
	input wire logic RST_N_IN,
	input wire logic LINK_RX_FRAME_IN,
	input wire logic LINK_TX_OK_IN,
	input wire logic RX_TYPE_VALID_IN,
	input wire logic RX_IS_PIO_SETUP_IN,
	input wire host_transport_idle_pkg::idle_state_t STATE_OUT,
	input wire logic CMD_PENDING_OUT,
	input wire logic CTRL_PENDING_OUT,
	input wire logic PIO_SETUP_SEEN_OUT,
	input wire logic SOFT_RESET_OUT
);
	import host_transport_idle_pkg::*;
	localparam idle_state_t IDL = TRANSPORT_IDLE_STATE;
	localparam idle_state_t CMD = COMMAND_FRAME_BUILD_STATE;
	localparam idle_state_t CTL = CONTROL_FRAME_BUILD_STATE;
	localparam idle_state_t CHK = FRAME_TYPE_CHECK_STATE;
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RST_N_IN);
	property p_rx; STATE_OUT == IDL && LINK_RX_FRAME_IN |=> STATE_OUT == CHK; endproperty
	a_rx: assert property (p_rx) else $error("receive not taken first");
	// Pending outputs lag the internal flag by one edge
	property p_cmd;
		$past(STATE_OUT) == IDL && !$past(LINK_RX_FRAME_IN) && CMD_PENDING_OUT |-> STATE_OUT == CMD;
	endproperty
	a_cmd: assert property (p_cmd) else $error("command frame not dispatched");
	property p_ctl;
		$past(STATE_OUT) == IDL && !$past(LINK_RX_FRAME_IN) && !CMD_PENDING_OUT
			&& CTRL_PENDING_OUT |-> STATE_OUT == CTL;
	endproperty
	a_ctl: assert property (p_ctl) else $error("control frame not dispatched");
	property p_txok;
		STATE_OUT == CMD && LINK_TX_OK_IN && !LINK_RX_FRAME_IN |=> STATE_OUT == IDL ##1 !CMD_PENDING_OUT;
	endproperty
	a_txok: assert property (p_txok) else $error("command pending not cleared");
	property p_defer;
		STATE_OUT == CMD && LINK_RX_FRAME_IN && !LINK_TX_OK_IN |=> STATE_OUT == CHK && CMD_PENDING_OUT;
	endproperty
	a_defer: assert property (p_defer) else $error("pending frame not deferred");
	property p_soft_reset_bit; $changed(SOFT_RESET_OUT) |-> CTRL_PENDING_OUT; endproperty
	a_soft_reset_bit: assert property (p_soft_reset_bit) else $error("no control frame on change");
	property p_abandon; $changed(SOFT_RESET_OUT) |-> !CMD_PENDING_OUT; endproperty
	a_abandon: assert property (p_abandon) else $error("command not abandoned");
	property p_pio;
		RX_TYPE_VALID_IN |-> ##2 PIO_SETUP_SEEN_OUT == $past(RX_IS_PIO_SETUP_IN, 2);
	endproperty
	a_pio: assert property (p_pio) else $error("setup indication wrong");
	c_defer: cover property (STATE_OUT == CMD ##1 STATE_OUT == CHK);
	c_ctl: cover property (STATE_OUT == CTL);
	c_pio: cover property (STATE_OUT == PIO_OUTBOUND_TRANSFER_STATE);
endmodule : host_transport_idle_checker

// ---- link_partner_model.sv ----
`timescale 1ns/1ps
module link_partner_model (
	// Clock, reset, observed state
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire host_transport_idle_pkg::idle_state_t state_in,
	// Bench controls
	input wire logic rx_req_in,
	input wire logic pio_in,
	input wire logic [3:0] wait_in,
	// Toward the dispatcher
	output logic tx_ok_out,
	output logic rx_frame_out,
	output logic type_valid_out,
	output logic is_pio_out,
	output logic sub_done_out
);
	import host_transport_idle_pkg::*;
	logic [3:0] cnt_r;
	logic fire;
	logic build;
	assign build = state_in == COMMAND_FRAME_BUILD_STATE || state_in == CONTROL_FRAME_BUILD_STATE;
	// An arriving frame pre-empts our own completion
	assign fire = state_in != TRANSPORT_IDLE_STATE && cnt_r == wait_in && !rx_req_in;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || fire || rx_req_in || state_in == TRANSPORT_IDLE_STATE) begin
			cnt_r <= 4'h0;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
	assign rx_frame_out = rx_req_in;
	assign tx_ok_out = fire && build;
	assign type_valid_out = fire && state_in == FRAME_TYPE_CHECK_STATE;
	// Unqualified type line shows garbage
	assign is_pio_out = type_valid_out ? pio_in : ~pio_in;
	assign sub_done_out = fire && !build;
endmodule : link_partner_model

// ---- host_transport_idle_dispatch_bench.sv ----
`timescale 1ns/1ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin err_total++; $display("FAIL %s exp %h got %h", n, e, a); end end
module host_transport_idle_dispatch_bench;
	import host_transport_idle_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] ha = 32'h0, hd = 32'h0, hr, rd;
	logic [1:0] ht = 2'h0;
	logic hw = 1'b0, rxq = 1'b0, pio = 1'b0;
	logic [3:0] dly = 4'h3;
	logic txo, rxf, tv, tp, sd, cp, cq, ps, sr, hs;
	wire rdy;
	idle_state_t st;
	int err_total = 0, samples_checked = 0;
	always #2 clk = ~clk;
	host_transport_idle_dispatch host_transport_idle_dispatch_inst (.MCLK_IN(clk), .RST_N_IN(rst_n),
		.HSEL_IN(1'b1), .HADDR_IN(ha), .HTRANS_IN(ht), .HWRITE_IN(hw), .HSIZE_IN(3'h2),
		.HWDATA_IN(hd), .HREADY_IN(rdy), .HREADYOUT_OUT(rdy), .HRESP_OUT(hs), .HRDATA_OUT(hr),
		.LINK_RX_FRAME_IN(rxf), .LINK_TX_OK_IN(txo), .RX_TYPE_VALID_IN(tv),
		.RX_IS_PIO_SETUP_IN(tp), .SUB_DONE_IN(sd), .STATE_OUT(st), .CMD_PENDING_OUT(cp),
		.CTRL_PENDING_OUT(cq), .PIO_SETUP_SEEN_OUT(ps), .SOFT_RESET_OUT(sr));
	link_partner_model link_partner_model_inst (.clk_in(clk), .rst_n_in(rst_n), .state_in(st),
		.rx_req_in(rxq), .pio_in(pio), .wait_in(dly), .tx_ok_out(txo), .rx_frame_out(rxf),
		.type_valid_out(tv), .is_pio_out(tp), .sub_done_out(sd));
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		ha <= {24'h0, a};
		hw <= w;
		ht <= HTRANS_NONSEQ;
		do @(posedge clk); while (rdy !== 1'b1);
		ht <= 2'h0;
		hd <= d;
		do @(posedge clk); while (rdy !== 1'b1);
		rd = hr;
	endtask : bus
	task automatic wait_st(input idle_state_t s);
		int n;
		n = 0;
		while (st !== s && n < 64) begin
			@(posedge clk);
			n++;
		end
		`CHK("state", s, st)
	endtask : wait_st
	task automatic t_cmd();
		bus(1'b1, CMD_SHADOW_OFS, 32'h5a);
		wait_st(COMMAND_FRAME_BUILD_STATE);
		`CHK("cmd pend", 1'b1, cp)
		wait_st(TRANSPORT_IDLE_STATE);
		bus(1'b0, CMD_SHADOW_OFS, 32'h0);
		`CHK("cmd clr", 1'b0, cp)
		`CHK("cmd reg", 32'h5a, rd)
	endtask : t_cmd
	task automatic t_ctrl();
		dly <= 4'hf;
		bus(1'b1, CMD_SHADOW_OFS, 32'h11);
		bus(1'b1, DEV_CTRL_OFS, 32'h4);
		wait_st(CONTROL_FRAME_BUILD_STATE);
		`CHK("abandon", 1'b0, cp)
		`CHK("soft_reset_bit", 1'b1, sr)
		`CHK("ctrl pend", 1'b1, cq)
		wait_st(TRANSPORT_IDLE_STATE);
		bus(1'b1, DEV_CTRL_OFS, 32'h4);
		bus(1'b0, STATUS_OFS, 32'h0);
		`CHK("same soft_reset_bit", 1'b0, rd[STAT_CTRL_PEND_BIT])
		bus(1'b1, DEV_CTRL_OFS, 32'h0);
		wait_st(CONTROL_FRAME_BUILD_STATE);
		rxq <= 1'b1;
		@(posedge clk);
		rxq <= 1'b0;
		wait_st(FRAME_TYPE_CHECK_STATE);
		`CHK("ctrl kept", 1'b1, cq)
		wait_st(CONTROL_FRAME_BUILD_STATE);
		wait_st(TRANSPORT_IDLE_STATE);
	endtask : t_ctrl
	task automatic t_rx();
		dly <= 4'h2;
		pio <= 1'b1;
		bus(1'b1, CMD_SHADOW_OFS, 32'h22);
		rxq <= 1'b1;
		@(posedge clk);
		rxq <= 1'b0;
		wait_st(FRAME_TYPE_CHECK_STATE);
		`CHK("kept", 1'b1, cp)
		wait_st(COMMAND_FRAME_BUILD_STATE);
		`CHK("pio seen", 1'b1, ps)
		rxq <= 1'b1;
		@(posedge clk);
		rxq <= 1'b0;
		wait_st(FRAME_TYPE_CHECK_STATE);
		wait_st(COMMAND_FRAME_BUILD_STATE);
		wait_st(TRANSPORT_IDLE_STATE);
	endtask : t_rx
	task automatic t_req();
		for (int i = 0; i < 2; i++) begin
			bus(1'b1, APP_REQ_OFS, 32'h1 << i);
			wait_st(i ? SELF_TEST_TRANSMIT_STATE : DMA_SETUP_TRANSMIT_STATE);
			wait_st(TRANSPORT_IDLE_STATE);
		end
	endtask : t_req
	task automatic t_pio();
		bus(1'b1, APP_REQ_OFS, 32'h4);
		bus(1'b0, STATUS_OFS, 32'h0);
		`CHK("h2d", 1'b1, rd[STAT_H2D_BIT])
		`CHK("no data idle", 7'h01, rd[6:0])
		bus(1'b1, DATA_SHADOW_OFS, 32'hc3a5_0f96);
		wait_st(PIO_OUTBOUND_TRANSFER_STATE);
		wait_st(TRANSPORT_IDLE_STATE);
		bus(1'b0, DATA_SHADOW_OFS, 32'h0);
		`CHK("data reg", 32'hc3a5_0f96, rd)
		bus(1'b0, 8'h14, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		`CHK("resp", HRESP_OKAY, hs)
	endtask : t_pio
	task automatic tally_and_finish();
		if (err_total == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		`CHK("reset", TRANSPORT_IDLE_STATE, st)
		t_cmd();
		t_ctrl();
		t_rx();
		t_req();
		t_pio();
		tally_and_finish();
	end
	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		tally_and_finish();
	end
endmodule : host_transport_idle_dispatch_bench
bind host_transport_idle_dispatch host_transport_idle_checker host_transport_idle_checker_inst (
	.MCLK_IN, .RST_N_IN, .LINK_RX_FRAME_IN, .LINK_TX_OK_IN, .RX_TYPE_VALID_IN, .RX_IS_PIO_SETUP_IN,
	.STATE_OUT, .CMD_PENDING_OUT, .CTRL_PENDING_OUT, .PIO_SETUP_SEEN_OUT, .SOFT_RESET_OUT);
